//--- cpes_chk.sv
// Purpose: Port checks for cpes_top
// Assumes: level_o and rdata_o lag state by one cycle
// Notes: Bound at foot
`timescale 1ns/10ps
module cpes_chk
#(parameter int unsigned NUM_EXT = cpes_pkg::CPES_NUM_EXT)
(
	input wire logic clk_i, // Clock
	input wire logic rst_i, // Reset
	input wire logic [cpes_pkg::CPES_ADDR_W-1:0] addr_i, // Index
	input wire logic rd_i, // Read strobe
	input wire logic level_load_i, // Core load
	input wire logic [3:0] level_val_i, // Load value
	input wire logic [cpes_pkg::CPES_DATA_W-1:0] rdata_o, // Read data
	input wire cpes_pkg::cpes_level_type level_o, // Level
	input wire logic [NUM_EXT-1:0] ext_event_o // Events
);
	import cpes_pkg::*;

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_load; level_load_i |-> ##2 level_o.level == $past(level_val_i, 2); endproperty
	a_load: assert property (p_load) else $error("load lost");
	property p_blk_hi; level_o.level[3] |-> level_o.user_blocked; endproperty
	a_blk_hi: assert property (p_blk_hi) else $error("high not blocked");
	property p_blk_7; level_o.level[2:0] == CPES_LVL_LO_MAX |-> level_o.user_blocked; endproperty
	a_blk_7: assert property (p_blk_7) else $error("seven not blocked");
	property p_blk_lo; level_o.user_blocked |-> level_o.level >= 4'h7; endproperty
	a_blk_lo: assert property (p_blk_lo) else $error("low blocked");
	property p_hi_rise; $rose(level_o.level[3]) |-> $past(level_load_i, 2) && $past(level_val_i, 2) >= 4'h8; endproperty
	a_hi_rise: assert property (p_hi_rise) else $error("high bit set");
	property p_rd_lvl; rd_i && addr_i == CPES_OFF_STATUS |=> rdata_o[7:5] == level_o.level[2:0]; endproperty
	a_rd_lvl: assert property (p_rd_lvl) else $error("field read");
	property p_rd_alt; rd_i && addr_i == CPES_OFF_ICTL_TWO |=> rdata_o[15] == level_o.alt_vector; endproperty
	a_rd_alt: assert property (p_rd_alt) else $error("alt read");
	property p_pulse; |ext_event_o |=> (ext_event_o & $past(ext_event_o)) == '0; endproperty
	a_pulse: assert property (p_pulse) else $error("event width");
	c_blk: cover property (level_o.user_blocked);
	c_evt: cover property (|ext_event_o);
	c_load: cover property (level_load_i ##2 level_o.level[3]);
endmodule // cpes_chk

bind cpes_top cpes_chk #(.NUM_EXT(NUM_EXT)) i_chk (.clk_i, .rst_i, .addr_i, .rd_i, .level_load_i,
	.level_val_i, .rdata_o, .level_o, .ext_event_o);

//--- cpes_edge_det.sv
// Purpose: One external interrupt input: synchroniser and polarity edge detect
// Assumes: Pin is asynchronous to clk_i
// Notes: Emits a one-cycle pulse on the selected edge
`timescale 1ns/10ps
module cpes_edge_det
(
	input wire logic clk_i, // System clock
	input wire logic rst_i, // Synchronous reset, active high
	input wire logic pin_i, // Raw external interrupt pin
	input wire logic falling_i, // 1 falling edge, 0 rising edge
	output logic pulse_o // One-cycle edge event
);
	import cpes_pkg::*;

	logic sync1_q;
	logic sync2_q;
	logic prev_q;

	// =====================================================
	// Two-stage synchroniser then edge detect
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			prev_q <= 1'b0;
			pulse_o <= 1'b0;
		end
		else
		begin
			sync1_q <= pin_i;
			sync2_q <= sync1_q;
			prev_q <= sync2_q;
			pulse_o <= falling_i ? (prev_q & ~sync2_q) : (~prev_q & sync2_q);
		end
	end
endmodule // cpes_edge_det

//--- cpes_pin_model.sv
// Purpose: External interrupt pins
// Assumes: Pins start low
// Notes: Each flip bit toggles its pin on every rising clock edge at which it is high
`timescale 1ns/10ps
module cpes_pin_model
(
	input wire logic clk_i, // Clock
	input wire logic [4:0] flip_i, // Toggle request
	output logic [4:0] pin_o // Pin levels
);
	initial pin_o = 5'h00;
	always @(posedge clk_i) pin_o <= pin_o ^ flip_i;
endmodule // cpes_pin_model

//--- cpes_pkg.sv
// Purpose: Shared constants and types for the priority and edge select block
// Assumes: 16-bit register port, one clock
// Notes: Register offsets are word indices on the plain register port
package cpes_pkg;
	localparam int unsigned CPES_DATA_W = 16;
	localparam int unsigned CPES_ADDR_W = 4;
	localparam int unsigned CPES_NUM_EXT = 5;

	// =====================================================
	// Register offsets
	localparam logic [3:0] CPES_OFF_STATUS = 4'h0;
	localparam logic [3:0] CPES_OFF_CORE = 4'h1;
	localparam logic [3:0] CPES_OFF_ICTL_ONE = 4'h2;
	localparam logic [3:0] CPES_OFF_ICTL_TWO = 4'h3;
	localparam logic [3:0] CPES_OFF_IRQ_STAT = 4'h4;
	localparam logic [3:0] CPES_OFF_IRQ_MASK = 4'h5;

	// =====================================================
	// Field positions
	localparam int unsigned CPES_LVL_LO_POS = 5;
	localparam int unsigned CPES_LVL_HI_POS = 3;
	localparam int unsigned CPES_NEST_DIS_POS = 15;
	localparam int unsigned CPES_ALT_VEC_POS = 15;
	localparam int unsigned CPES_REP_SUP_POS = 14;
	localparam int unsigned CPES_POL_POS = 0;

	// =====================================================
	// Reset values and level figures
	localparam logic [2:0] CPES_LVL_LO_RST = 3'h0;
	localparam logic [2:0] CPES_LVL_LO_MAX = 3'h7;
	localparam logic [4:0] CPES_POL_RST = 5'h00;
	localparam logic [15:0] CPES_ZERO16 = 16'h0000;

	typedef struct packed {
		logic [CPES_ADDR_W-1:0] addr;
		logic [CPES_DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} cpes_req_type;

	typedef struct packed {
		logic [3:0] level;
		logic user_blocked;
		logic alt_vector;
	} cpes_level_type;

	typedef enum logic [1:0] {
		CPES_EDGE_IDLE = 2'b00,
		CPES_EDGE_SEEN = 2'b01
	} cpes_edge_state_type;
endpackage

//--- cpes_top.sv
// Purpose: CPU priority level holding and external interrupt edge selection
// Assumes: Plain register port, read data one cycle after read strobe
// Notes: Edge events latch into sticky status, masked onto irq_o
//
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
module cpes_top
#(
	parameter int unsigned NUM_EXT = cpes_pkg::CPES_NUM_EXT
)
(
	input wire logic clk_i, // System clock, 200 MHz
	input wire logic rst_i, // Synchronous reset, active high
	input wire logic [cpes_pkg::CPES_ADDR_W-1:0] addr_i, // Register index
	input wire logic [cpes_pkg::CPES_DATA_W-1:0] wdata_i, // Write data
	input wire logic wr_i, // Write strobe
	input wire logic rd_i, // Read strobe
	input wire logic level_load_i, // Core loads a new level
	input wire logic [3:0] level_val_i, // Level value to load
	input wire logic rep_sup_i, // Repeat-suppress activity from core
	input wire logic [NUM_EXT-1:0] ext_pin_i, // External interrupt pins
	output logic [cpes_pkg::CPES_DATA_W-1:0] rdata_o, // Read data
	output cpes_pkg::cpes_level_type level_o, // Effective level and blocking
	output logic [NUM_EXT-1:0] ext_event_o, // Edge event pulses
	output logic irq_o // Unmasked status pending
);
	import cpes_pkg::*;

	cpes_req_type req;
	logic [2:0] cpu_level_low_field_q;
	logic cpu_level_high_bit_q;
	logic nesting_disable_q;
	logic alternate_vector_select_q;
	logic rep_sup_q;
	logic [NUM_EXT-1:0] pol_q;
	logic [NUM_EXT-1:0] stat_q;
	logic [NUM_EXT-1:0] mask_q;
	logic [NUM_EXT-1:0] edge_pulse;
	logic [CPES_DATA_W-1:0] rd_mux;
	logic [3:0] eff_level;
	logic wr_status;
	logic wr_core;
	logic wr_ictl1;
	logic wr_ictl2;
	logic wr_irq_stat;
	logic wr_irq_mask;
	logic [2:0] cpu_level_low_field_d;
	logic cpu_level_high_bit_d;
	logic [NUM_EXT-1:0] stat_d;
	logic user_blocked_d;

	// =====================================================
	// Register write decode
	assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
	assign wr_status = req.wr && (req.addr == CPES_OFF_STATUS);
	assign wr_core = req.wr && (req.addr == CPES_OFF_CORE);
	assign wr_ictl1 = req.wr && (req.addr == CPES_OFF_ICTL_ONE);
	assign wr_ictl2 = req.wr && (req.addr == CPES_OFF_ICTL_TWO);
	assign wr_irq_stat = req.wr && (req.addr == CPES_OFF_IRQ_STAT);
	assign wr_irq_mask = req.wr && (req.addr == CPES_OFF_IRQ_MASK);

	// =====================================================
	// Edge detectors, one per external input
	genvar g;
	generate
		for (g = 0; g < NUM_EXT; g++)
		begin : g_ext
			cpes_edge_det u_det (
				.clk_i(clk_i),
				.rst_i(rst_i),
				.pin_i(ext_pin_i[g]),
				.falling_i(pol_q[g]),
				.pulse_o(edge_pulse[g])
			);
		end
	endgenerate

	// =====================================================
	// Priority level field, core load wins over software
	always_comb
	begin
		cpu_level_low_field_d = cpu_level_low_field_q;
		if (level_load_i)
		begin
			cpu_level_low_field_d = level_val_i[2:0];
		end
		else if (wr_status && !nesting_disable_q)
		begin
			cpu_level_low_field_d = req.wdata[CPES_LVL_LO_POS +: 3];
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cpu_level_low_field_q <= CPES_LVL_LO_RST;
		end
		else
		begin
			cpu_level_low_field_q <= cpu_level_low_field_d;
		end
	end

	// =====================================================
	// Upper level bit: core may set, software may only clear
	always_comb
	begin
		cpu_level_high_bit_d = cpu_level_high_bit_q;
		if (level_load_i)
		begin
			cpu_level_high_bit_d = level_val_i[3];
		end
		else if (wr_core && !req.wdata[CPES_LVL_HI_POS])
		begin
			cpu_level_high_bit_d = 1'b0;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cpu_level_high_bit_q <= 1'b0;
		end
		else
		begin
			cpu_level_high_bit_q <= cpu_level_high_bit_d;
		end
	end

	// =====================================================
	// Nesting disable
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			nesting_disable_q <= 1'b0;
		end
		else if (wr_ictl1)
		begin
			nesting_disable_q <= req.wdata[CPES_NEST_DIS_POS];
		end
	end

	// Alternate vector select
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			alternate_vector_select_q <= 1'b0;
		end
		else if (wr_ictl2)
		begin
			alternate_vector_select_q <= req.wdata[CPES_ALT_VEC_POS];
		end
	end

	// Edge polarity per external input
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			pol_q <= CPES_POL_RST[NUM_EXT-1:0];
		end
		else if (wr_ictl2)
		begin
			pol_q <= req.wdata[CPES_POL_POS +: NUM_EXT];
		end
	end

	// Repeat-suppress activity, shown one cycle late
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			rep_sup_q <= 1'b0;
		end
		else
		begin
			rep_sup_q <= rep_sup_i;
		end
	end

	// =====================================================
	// Sticky event status; set wins over clear
	always_comb
	begin
		stat_d = stat_q | edge_pulse;
		if (wr_irq_stat)
		begin
			stat_d = (stat_q & ~req.wdata[NUM_EXT-1:0]) | edge_pulse;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			stat_q <= '0;
		end
		else
		begin
			stat_q <= stat_d;
		end
	end

	// Interrupt mask
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			mask_q <= '0;
		end
		else if (wr_irq_mask)
		begin
			mask_q <= req.wdata[NUM_EXT-1:0];
		end
	end

	// =====================================================
	// Effective level and blocking
	assign eff_level = {cpu_level_high_bit_q, cpu_level_low_field_q};
	assign user_blocked_d = cpu_level_high_bit_q
		|| (cpu_level_low_field_q == CPES_LVL_LO_MAX);

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			level_o <= '0;
		end
		else
		begin
			level_o.level <= eff_level;
			level_o.user_blocked <= user_blocked_d;
			level_o.alt_vector <= alternate_vector_select_q;
		end
	end

	// =====================================================
	// Event pulses and interrupt output
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ext_event_o <= '0;
		end
		else
		begin
			ext_event_o <= edge_pulse;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			irq_o <= 1'b0;
		end
		else
		begin
			irq_o <= |(stat_q & mask_q);
		end
	end

	// =====================================================
	// Register read
	always_comb
	begin
		rd_mux = CPES_ZERO16;
		case (req.addr)
			CPES_OFF_STATUS: rd_mux[CPES_LVL_LO_POS +: 3] = cpu_level_low_field_q;
			CPES_OFF_CORE: rd_mux[CPES_LVL_HI_POS] = cpu_level_high_bit_q;
			CPES_OFF_ICTL_ONE: rd_mux[CPES_NEST_DIS_POS] = nesting_disable_q;
			CPES_OFF_ICTL_TWO:
			begin
				rd_mux[CPES_ALT_VEC_POS] = alternate_vector_select_q;
				rd_mux[CPES_REP_SUP_POS] = rep_sup_q;
				rd_mux[CPES_POL_POS +: NUM_EXT] = pol_q;
			end
			CPES_OFF_IRQ_STAT: rd_mux[NUM_EXT-1:0] = stat_q;
			CPES_OFF_IRQ_MASK: rd_mux[NUM_EXT-1:0] = mask_q;
			default: rd_mux = CPES_ZERO16;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			rdata_o <= CPES_ZERO16;
		end
		else if (req.rd)
		begin
			rdata_o <= rd_mux;
		end
		else
		begin
			rdata_o <= CPES_ZERO16;
		end
	end
endmodule // cpes_top

//--- cpes_top_tb.sv
// Purpose: Register and pin tests of cpes_top
// Assumes: Offsets from cpes_pkg
// Notes: Self-checking
`timescale 1ns/10ps
module cpes_top_tb;
	import cpes_pkg::*;
	logic clk_i, rst_i, wr_i, rd_i, level_load_i, rep_sup_i, irq_o;
	logic [3:0] addr_i, level_val_i;
	logic [15:0] wdata_i, rdata_o;
	logic [4:0] flip, ext_pin_i, ext_event_o;
	cpes_level_type level_o;
	int fails, tests_run, c;
	cpes_top i_dut (.clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .level_load_i, .level_val_i,
		.rep_sup_i, .ext_pin_i, .rdata_o, .level_o, .ext_event_o, .irq_o);
	cpes_pin_model i_pins (.clk_i, .flip_i(flip), .pin_o(ext_pin_i));
	initial
	begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	task results;
		if (fails == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task chk(input logic [15:0] g, input logic [15:0] e);
		tests_run++;
		fails += int'(g !== e);
		if (g !== e) $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
	endtask
	task wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	task rd(input logic [3:0] a, input logic [15:0] e);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 chk(rdata_o, e);
	endtask
	task lv(input logic [5:0] e);
		repeat (2) @(posedge clk_i);
		#1 chk({10'h000, level_o}, {10'h000, e});
	endtask
	task pin(input logic [4:0] p, input logic [15:0] e, input logic q);
		logic [4:0] ev;
		ev = 5'h00;
		@(posedge clk_i);
		flip <= p;
		@(posedge clk_i);
		flip <= 5'h00;
		repeat (8)
		begin
			@(posedge clk_i);
			#1 ev = ev | ext_event_o;
		end
		chk({11'h000, ev}, e);
		rd(CPES_OFF_IRQ_STAT, e);
		chk({15'h0000, irq_o}, {15'h0000, q});
		wr(CPES_OFF_IRQ_STAT, 16'h001F);
	endtask
	initial
	begin
		{fails, tests_run} = 0;
		{wr_i, rd_i, addr_i, wdata_i, level_load_i, level_val_i, rep_sup_i, flip} = '0;
		rst_i = 1'b1;
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		for (c = 0; c < 4; c++) rd(c[3:0], 16'h0000);
		for (c = 0; c < 8; c++)
		begin
			wr(CPES_OFF_STATUS, 16'(c << 5));
			rd(CPES_OFF_STATUS, 16'(c << 5));
			lv({c[3:0], c == 7, 1'b0});
		end
		@(posedge clk_i);
		level_load_i <= 1'b1;
		level_val_i <= 4'hB;
		rep_sup_i <= 1'b1;
		@(posedge clk_i);
		level_load_i <= 1'b0;
		lv(6'h2E);
		rd(CPES_OFF_CORE, 16'h0008);
		rd(CPES_OFF_STATUS, 16'h0060);
		wr(CPES_OFF_CORE, 16'h0000);
		lv(6'h0C);
		wr(CPES_OFF_CORE, 16'h0008);
		rd(CPES_OFF_CORE, 16'h0000);
		wr(CPES_OFF_ICTL_ONE, 16'h8000);
		wr(CPES_OFF_STATUS, 16'h00A0);
		rd(CPES_OFF_STATUS, 16'h0060);
		wr(CPES_OFF_ICTL_ONE, 16'h0000);
		wr(CPES_OFF_STATUS, 16'h00A0);
		rd(CPES_OFF_STATUS, 16'h00A0);
		wr(CPES_OFF_ICTL_TWO, 16'h8000);
		lv(6'h15);
		rd(CPES_OFF_ICTL_TWO, 16'hC000);
		wr(4'h6, 16'hFFFF);
		rd(4'h6, 16'h0000);
		wr(CPES_OFF_IRQ_MASK, 16'h001F);
		pin(5'h05, 16'h0005, 1'b1);
		pin(5'h1F, 16'h001A, 1'b1);
		wr(CPES_OFF_ICTL_TWO, 16'h801F);
		rd(CPES_OFF_ICTL_TWO, 16'hC01F);
		wr(CPES_OFF_IRQ_MASK, 16'h0000);
		pin(5'h1F, 16'h001A, 1'b0);
		results;
	end
	initial
	begin
		repeat (4000) @(posedge clk_i);
		fails++;
		results;
	end
endmodule // cpes_top_tb
